// ---- prdiv_pkg.sv ----
package prdiv_pkg;

    // bus geometry
    localparam int          PRDIV_DW          = 32;
    localparam int          PRDIV_IW          = 10;
    localparam logic [1:0]  PRDIV_HTRANS_NSEQ = 2'b10;
    localparam logic [1:0]  PRDIV_HTRANS_SEQ  = 2'b11;

    // register indices; byte address is four times the index
    localparam logic [9:0]  PRDIV_CTRL_IDX    = 10'h007;
    localparam logic [9:0]  PRDIV_STAT_IDX    = 10'h008;
    localparam logic [9:0]  PRDIV_IEN_IDX     = 10'h009;
    localparam logic [9:0]  PRDIV_ICLR_IDX    = 10'h00a;
    localparam logic [9:0]  PRDIV_MODCNT_IDX  = 10'h00b;
    localparam logic [9:0]  PRDIV_PRECNT_IDX  = 10'h00c;

    // control register layout
    localparam int          PRDIV_CTRL_W      = 8;
    localparam int          PRDIV_DEC_BIT     = 7;
    localparam int          PRDIV_PRE_MSB     = 6;
    localparam int          PRDIV_PRE_LSB     = 4;
    localparam int          PRDIV_MOD_MSB     = 3;
    localparam int          PRDIV_MOD_LSB     = 0;
    localparam logic [7:0]  PRDIV_CTRL_RST    = 8'h00;

    // event bits of status, enable and clear
    localparam int          PRDIV_NEV         = 2;
    localparam int          PRDIV_EV_TIMEOUT  = 0;
    localparam int          PRDIV_EV_OVERRUN  = 1;
    localparam logic [1:0]  PRDIV_STAT_RST    = 2'h0;
    localparam logic [1:0]  PRDIV_IEN_RST     = 2'h0;

    // divider chain
    localparam int          PRDIV_PRE_W       = 18;
    localparam int          PRDIV_MOD_W       = 4;
    localparam int          PRDIV_BIN_SHIFT   = 10;
    localparam int          PRDIV_DEC_UNIT    = 1000;
    localparam logic [2:0]  PRDIV_PRE_OFF     = 3'h0;
    localparam int          PRDIV_DEC_MULT [0:7] = '{1, 2, 5, 10, 20, 50, 100, 200};

    typedef enum logic [1:0] {
        PRDIV_BUS_IDLE  = 2'b00,
        PRDIV_BUS_WRITE = 2'b01,
        PRDIV_BUS_READ  = 2'b11,
        PRDIV_BUS_RDATA = 2'b10
    } prdiv_bus_t;

endpackage : prdiv_pkg

// ---- prdiv_prescaler.sv ----
module prdiv_prescaler
    import prdiv_pkg::*;
#(
    parameter int PW = PRDIV_PRE_W
) (
    input  wire logic          mclk,
    input  wire logic          srst,
    input  wire logic          restart,
    input  wire logic          enable,
    input  wire logic [PW-1:0] ratio,
    output logic      [PW-1:0] count,
    output logic               tick
);

    logic [PW-1:0] cnt_r;
    logic          tick_r;
    logic [PW-1:0] last;

    assign last  = ratio - PW'(1);
    assign count = cnt_r;
    assign tick  = tick_r;

    always_ff @(posedge mclk) begin
        if (srst || restart || !enable) begin
            cnt_r <= '0;
        end else if (cnt_r >= last) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + PW'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || restart || !enable) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= (cnt_r >= last);
        end
    end

endmodule : prdiv_prescaler

// ---- prdiv_modulus.sv ----
module prdiv_modulus
    import prdiv_pkg::*;
#(
    parameter int MW = PRDIV_MOD_W
) (
    input  wire logic          mclk,
    input  wire logic          srst,
    input  wire logic          restart,
    input  wire logic          tick,
    input  wire logic [MW-1:0] target,
    output logic      [MW-1:0] count,
    output logic               done
);

    logic [MW-1:0] cnt_r;
    logic          done_r;

    assign count = cnt_r;
    assign done  = done_r;

    // target n divides the prescaled ticks by n+1
    always_ff @(posedge mclk) begin
        if (srst || restart) begin
            cnt_r <= '0;
        end else if (tick) begin
            if (cnt_r >= target) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + MW'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || restart) begin
            done_r <= 1'b0;
        end else begin
            done_r <= tick && (cnt_r >= target);
        end
    end

endmodule : prdiv_modulus

// ---- prdiv_top.sv ----
module prdiv_top
    import prdiv_pkg::*;
#(
    parameter int BIN_SHIFT = PRDIV_BIN_SHIFT,
    parameter int DEC_UNIT  = PRDIV_DEC_UNIT,
    parameter int PW        = PRDIV_PRE_W
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             periodic_timeout_interrupt,
    output logic             timeout_pulse
);

    prdiv_bus_t              bus_r;
    prdiv_bus_t              bus_nxt;
    logic [PRDIV_IW-1:0]     idx_r;
    logic [31:0]             hrdata_r;
    logic                    hreadyout_r;
    logic                    hresp_r;
    logic                    irq_r;
    logic                    pulse_r;

    logic [PRDIV_CTRL_W-1:0] ctrl_r;
    logic [PRDIV_NEV-1:0]    status_r;
    logic [PRDIV_NEV-1:0]    status_nxt;
    logic [PRDIV_NEV-1:0]    ien_r;
    logic [PRDIV_NEV-1:0]    event_set;
    logic [PRDIV_NEV-1:0]    event_clr;

    logic                    accept;
    logic                    wr_commit;
    logic                    wr_ctrl;
    logic                    wr_ien;
    logic                    wr_clr;
    logic [31:0]             rd_mux;

    logic                    decimal_ratio_select;
    logic [2:0]              prescale_select;
    logic [PRDIV_MOD_W-1:0]  modulus_select;
    logic                    chain_on;
    logic [PW-1:0]           ratio;
    logic [PW-1:0]           pre_count;
    logic                    pre_tick;
    logic [PRDIV_MOD_W-1:0]  mod_count;
    logic                    period_done;

    // ---------------- bus slave ----------------

    assign accept    = hsel && hready && (htrans[1] == PRDIV_HTRANS_NSEQ[1]);
    assign wr_commit = (bus_r == PRDIV_BUS_WRITE) && hready;
    assign wr_ctrl   = wr_commit && (idx_r == PRDIV_CTRL_IDX);
    assign wr_ien    = wr_commit && (idx_r == PRDIV_IEN_IDX);
    assign wr_clr    = wr_commit && (idx_r == PRDIV_ICLR_IDX);

    always_comb begin
        bus_nxt = bus_r;
        case (bus_r)
            PRDIV_BUS_IDLE, PRDIV_BUS_WRITE, PRDIV_BUS_RDATA: begin
                if (hready) begin
                    if (accept) begin
                        bus_nxt = hwrite ? PRDIV_BUS_WRITE : PRDIV_BUS_READ;
                    end else begin
                        bus_nxt = PRDIV_BUS_IDLE;
                    end
                end
            end
            PRDIV_BUS_READ: begin
                bus_nxt = PRDIV_BUS_RDATA;
            end
            default: begin
                bus_nxt = PRDIV_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            bus_r <= PRDIV_BUS_IDLE;
        end else begin
            bus_r <= bus_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            idx_r <= '0;
        end else if (accept && (bus_r != PRDIV_BUS_READ)) begin
            idx_r <= haddr[PRDIV_IW+1:2];
        end
    end

    // reads take one wait state so that a write just before is already visible
    always_ff @(posedge mclk) begin
        if (srst) begin
            hreadyout_r <= 1'b1;
        end else if (bus_nxt == PRDIV_BUS_READ) begin
            hreadyout_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx_r)
            PRDIV_CTRL_IDX: begin
                rd_mux[PRDIV_CTRL_W-1:0] = ctrl_r;
            end
            PRDIV_STAT_IDX: begin
                rd_mux[PRDIV_NEV-1:0] = status_r;
            end
            PRDIV_IEN_IDX: begin
                rd_mux[PRDIV_NEV-1:0] = ien_r;
            end
            PRDIV_MODCNT_IDX: begin
                rd_mux[PRDIV_MOD_W-1:0] = mod_count;
                rd_mux[31]              = chain_on;
            end
            PRDIV_PRECNT_IDX: begin
                rd_mux[PW-1:0] = pre_count;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            hrdata_r <= 32'h0000_0000;
        end else if (bus_r == PRDIV_BUS_READ) begin
            hrdata_r <= rd_mux;
        end
    end

    // ---------------- registers ----------------

    // only the low byte is kept; hsize is taken as a whole word
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_r <= PRDIV_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= hwdata[PRDIV_CTRL_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ien_r <= PRDIV_IEN_RST;
        end else if (wr_ien) begin
            ien_r <= hwdata[PRDIV_NEV-1:0];
        end
    end

    // overrun marks a period that ended while the previous one was still unacknowledged
    always_comb begin
        event_set                   = '0;
        event_set[PRDIV_EV_TIMEOUT] = period_done;
        event_set[PRDIV_EV_OVERRUN] = period_done && status_r[PRDIV_EV_TIMEOUT];
        event_clr                   = wr_clr ? hwdata[PRDIV_NEV-1:0] : '0;
        // a new event beats a clear in the same cycle
        status_nxt                  = (status_r & ~event_clr) | event_set;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            status_r <= PRDIV_STAT_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_nxt & ien_r);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= period_done;
        end
    end

    // ---------------- divider chain ----------------

    assign decimal_ratio_select = ctrl_r[PRDIV_DEC_BIT];
    assign prescale_select      = ctrl_r[PRDIV_PRE_MSB:PRDIV_PRE_LSB];
    assign modulus_select       = ctrl_r[PRDIV_MOD_MSB:PRDIV_MOD_LSB];

    // binary code zero is the only off setting; decimal never switches off
    assign chain_on = decimal_ratio_select || (prescale_select != PRDIV_PRE_OFF);

    always_comb begin
        ratio = PW'(1);
        if (decimal_ratio_select) begin
            ratio = PW'(DEC_UNIT * PRDIV_DEC_MULT[prescale_select]);
        end else if (prescale_select != PRDIV_PRE_OFF) begin
            ratio = PW'(1) << (BIN_SHIFT + int'(prescale_select) - 1);
        end
    end

    // mclk is the oscillator clock; nothing here runs on a bus-derived clock
    prdiv_prescaler #(
        .PW      (PW)
    ) u_prescaler (
        .mclk    (mclk),
        .srst    (srst),
        .restart (wr_ctrl),
        .enable  (chain_on),
        .ratio   (ratio),
        .count   (pre_count),
        .tick    (pre_tick)
    );

    // prescale ticks feed the modulus stage, so the period is their product
    prdiv_modulus #(
        .MW      (PRDIV_MOD_W)
    ) u_modulus (
        .mclk    (mclk),
        .srst    (srst),
        .restart (wr_ctrl),
        .tick    (pre_tick),
        .target  (modulus_select),
        .count   (mod_count),
        .done    (period_done)
    );

    // ---------------- outputs ----------------

    assign hrdata                     = hrdata_r;
    assign hreadyout                  = hreadyout_r;
    assign hresp                      = hresp_r;
    assign periodic_timeout_interrupt = irq_r;
    assign timeout_pulse              = pulse_r;

endmodule : prdiv_top

// ---- prdiv_asserts.sv ----
module prdiv_checker
    import prdiv_pkg::*;
#(
    parameter int BIN_SHIFT = 10,
    parameter int DEC_UNIT  = 1000
) (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        periodic_timeout_interrupt,
    input wire logic        timeout_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] ctl_sh;
    logic       ien_sh;
    logic       aph_v;
    logic       aph_wr;
    logic [9:0] aph_idx;
    logic       ctl_wr;
    logic       val_r;
    int         cnt_r;
    int         age_r;

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    function automatic int per(logic [7:0] c);
        int m [0:7] = '{1, 2, 5, 10, 20, 50, 100, 200};
        if (!c[7])
            return (c[6:4] == 3'h0) ? 0 : (1 << (BIN_SHIFT + c[6:4] - 1)) * (c[3:0] + 1);
        return DEC_UNIT * m[c[6:4]] * (c[3:0] + 1);
    endfunction : per

    assign ctl_wr = aph_v && aph_wr && hready && aph_idx == PRDIV_CTRL_IDX;

    always_ff @(posedge mclk) begin
        if (srst) begin
            aph_v  <= 1'b0;
            ctl_sh <= 8'h00;
            ien_sh <= 1'b0;
        end else if (hready) begin
            aph_v   <= hsel & htrans[1];
            aph_wr  <= hwrite;
            aph_idx <= haddr[11:2];
            if (ctl_wr)
                ctl_sh <= hwdata[7:0];
            if (aph_v && aph_wr && aph_idx == PRDIV_IEN_IDX)
                ien_sh <= hwdata[0];
        end
    end

    // a pulse right after a write may belong to the old period, so it does not arm the check
    always_ff @(posedge mclk) begin
        if (srst || ctl_wr) begin
            cnt_r <= 0;
            age_r <= 0;
            val_r <= 1'b0;
        end else begin
            cnt_r <= timeout_pulse ? 1 : cnt_r + 1;
            if (age_r < 8)
                age_r <= age_r + 1;
            if (timeout_pulse)
                val_r <= (age_r >= 4);
        end
    end

    sequence s_rd_done;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_rd_ctl;
        hsel && hready && htrans[1] && !hwrite && haddr[11:2] == PRDIV_CTRL_IDX;
    endsequence

    property p_rd_wait;
        hsel && hready && htrans[1] && !hwrite |=> s_rd_done;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_ctl_read;
        s_rd_ctl |=> s_rd_done ##0 (hrdata == {24'h0, ctl_sh});
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_off;
        !ctl_sh[7] && ctl_sh[6:4] == 3'h0 && age_r >= 4 |-> !timeout_pulse;
    endproperty
    a_off: assert property (p_off) else $error("pulse while off");
    property p_restart;
        ctl_wr |-> ##3 !timeout_pulse [*3];
    endproperty
    a_restart: assert property (p_restart) else $error("no restart on write");
    property p_period;
        timeout_pulse && val_r |-> cnt_r == per(ctl_sh);
    endproperty
    a_period: assert property (p_period) else $error("period length wrong");
    property p_pulse_one;
        timeout_pulse |=> !timeout_pulse;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");
    property p_irq;
        timeout_pulse && ien_sh && $past(ien_sh) |-> periodic_timeout_interrupt;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule : prdiv_checker

// ---- prdiv_top_test.sv ----
`define chk(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end

module prdiv_top_test
    import prdiv_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int          BS    = 2;
    localparam int          DU    = 4;
    localparam logic [31:0] A_CTL = {20'h0, PRDIV_CTRL_IDX, 2'b00};
    localparam logic [31:0] A_STA = {20'h0, PRDIV_STAT_IDX, 2'b00};
    localparam logic [31:0] A_IEN = {20'h0, PRDIV_IEN_IDX, 2'b00};
    localparam logic [31:0] A_CLR = {20'h0, PRDIV_ICLR_IDX, 2'b00};
    logic        mclk   = 1'b0;
    logic        srst   = 1'b1;
    logic        hsel   = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr  = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rdv;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         irq;
    wire         pulse;
    int          err_total = 0;
    int          tests_run = 0;
    int          d0;
    int          d1;

    always #2.5 mclk = ~mclk;

    prdiv_top #(.BIN_SHIFT(BS), .DEC_UNIT(DU)) i_dut (.mclk(mclk), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .periodic_timeout_interrupt(irq), .timeout_pulse(pulse));

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic lost();
        err_total++;
        $display("unexpected at %0t: wait ran out", $time);
        close_out();
    endtask : lost

    task automatic rdy();
        int i;
        i = 0;
        do begin @(posedge mclk); i++; end while (hreadyout !== 1'b1 && i < 40);
        if (i >= 40) lost();
    endtask : rdy

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= PRDIV_HTRANS_NSEQ;
        hwrite <= w;
        rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rdv = hrdata;
    endtask : xfer

    task automatic wp(output int n);
        n = 0;
        do begin @(posedge mclk); n++; end while (pulse !== 1'b1 && n < 20000);
        if (n >= 20000) lost();
    endtask : wp

    task automatic quiet();
        int n;
        n = 0;
        repeat (300) begin @(posedge mclk); if (pulse !== 1'b0) n++; end
        `chk(n, 0)
    endtask : quiet

    function automatic int per(logic [7:0] c);
        int m [0:7] = '{1, 2, 5, 10, 20, 50, 100, 200};
        if (!c[7])
            return (1 << (BS + c[6:4] - 1)) * (c[3:0] + 1);
        return DU * m[c[6:4]] * (c[3:0] + 1);
    endfunction : per

    task automatic t_reset();
        xfer(1'b0, A_CTL, 32'h0);
        `chk(rdv, 32'h0)
        xfer(1'b0, 32'h100, 32'h0);
        `chk(rdv, 32'h0)
        quiet();
        xfer(1'b1, A_CTL, 32'h0f);
        xfer(1'b0, A_CTL, 32'h0);
        `chk(rdv, 32'h0f)
        quiet();
        xfer(1'b1, A_CTL, 32'hffffffa5);
        xfer(1'b0, A_CTL, 32'h0);
        `chk(rdv, 32'ha5)
    endtask : t_reset

    // binary codes 1..7, decimal codes 0..7, and the longest modulus
    task automatic t_per();
        logic [7:0] c;
        for (int k = 0; k < 16; k++) begin
            c = k < 8 ? {1'b1, 3'(k), 4'(7 - k)} : {1'b0, 3'(k - 8), 4'(k - 8)};
            if (k == 8) c = 8'h1f;
            xfer(1'b1, A_CTL, {24'h0, c});
            // skip a pulse left over from the period that the write cut short
            @(posedge mclk);
            wp(d0);
            wp(d1);
            `chk(d1, per(c))
            wp(d1);
            `chk(d1, per(c))
        end
    endtask : t_per

    task automatic t_restart();
        xfer(1'b1, A_CTL, 32'h33);
        @(posedge mclk);
        wp(d0);
        `chk(d0, per(8'h33) + 2)
        repeat (30) @(posedge mclk);
        xfer(1'b1, A_CTL, 32'h33);
        @(posedge mclk);
        wp(d1);
        `chk(d1, d0)
    endtask : t_restart

    task automatic t_irq();
        // earlier scenarios left both status bits set
        xfer(1'b1, A_CTL, 32'h0);
        xfer(1'b1, A_CLR, 32'h3);
        xfer(1'b1, A_IEN, 32'h1);
        xfer(1'b1, A_CTL, 32'h11);
        wp(d0);
        `chk(irq, 1'b1)
        wp(d1);
        xfer(1'b1, A_CTL, 32'h0);
        xfer(1'b0, A_STA, 32'h0);
        `chk(rdv[1:0], 2'b11)
        xfer(1'b1, A_CLR, 32'h3);
        xfer(1'b0, A_STA, 32'h0);
        `chk(rdv, 32'h0)
        `chk(irq, 1'b0)
        xfer(1'b1, A_IEN, 32'h0);
        xfer(1'b1, A_CTL, 32'h11);
        wp(d0);
        `chk(irq, 1'b0)
        xfer(1'b0, A_STA, 32'h0);
        `chk(rdv[0], 1'b1)
    endtask : t_irq

    initial begin
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        t_reset();
        t_per();
        t_restart();
        t_irq();
        close_out();
    end
endmodule : prdiv_top_test

bind prdiv_top prdiv_checker #(.BIN_SHIFT(BIN_SHIFT), .DEC_UNIT(DEC_UNIT)) u_chk (.mclk(mclk),
    .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .periodic_timeout_interrupt(periodic_timeout_interrupt), .timeout_pulse(timeout_pulse));
